/* File: src/qeu_regs.svh */
// Purpose: Register map, field positions and reset values of the encoder unit
// Assumes: Word-index offsets; byte address is four times the index
// Notes:   Definitions only
// Behaviour
// - Unit keeps running in Idle when stop_in_idle clear
// - Reset clears stop_in_idle bit
// - Unit halts in Idle when stop_in_idle set
// - Timer counts normally in Idle if allowed
// - Rollover, index, error, period, gate set flag
// - Flag stays set until software clears
// - Interrupt forwarded only when enable bit set
// - Control register at 0122, resets to zero
// - Filter control register at 0124, resets zero
// - Unimplemented bits read zero, ignore writes
// - Timer mode: position is count, maximum period
// - Count error sets flag, irq unless disabled
// - Sleep halts whole unit including timer
`ifndef QEU_REGS_SVH
`define QEU_REGS_SVH
// ==========================================================
// Register indices
`define QEU_IDX_CTRL    10'h122
`define QEU_IDX_FILT    10'h124
`define QEU_IDX_POS     10'h126
`define QEU_IDX_MAX     10'h128
`define QEU_IDX_PINSEL  10'h2A8
`define QEU_IDX_IRQST   10'h130
`define QEU_IDX_IRQEN   10'h131
// ==========================================================
// Write masks of implemented bits
`define QEU_MASK_CTRL   16'hBFBF
`define QEU_MASK_FILT   16'h07F0
`define QEU_MASK_PINSEL 16'h01FF
`define QEU_MASK_IRQ    16'h000F
// ==========================================================
// Reset values
`define QEU_RST_CTRL    16'h0000
`define QEU_RST_FILT    16'h0000
`define QEU_RST_POS     16'h0000
`define QEU_RST_MAX     16'hFFFF
`define QEU_RST_PINSEL  16'h0000
// ==========================================================
// Control fields
`define QEU_C_ERR   15
`define QEU_C_SIDL  13
`define QEU_C_INDEX 12
`define QEU_C_DIR   11
`define QEU_C_MODE  10:8
`define QEU_C_SWAP  7
`define QEU_C_GATE  5
`define QEU_C_PRE   4:3
`define QEU_C_POSR  2
`define QEU_C_TCS   1
`define QEU_C_DSRC  0
// Filter fields
`define QEU_F_IMV   10:9
`define QEU_F_COUNT_ERROR_IRQ_DISABLE  8
`define QEU_F_OUTEN 7
`define QEU_F_DIV   6:4
// Status bits
`define QEU_S_ROLL  0
`define QEU_S_INDEX 1
`define QEU_S_PER   2
`define QEU_S_GATE  3
// Filter stable length in samples
`define QEU_FILT_LEN 3
`endif

/* File: src/qeu_pkg.sv */
// Purpose: Shared types of the encoder unit
// Assumes: Mode codes as held in the control register
// Notes:   Mode decode used by logic and checks
package qeu_pkg;
  // ==========================================================
  // Types
  typedef logic [15:0] qeu_word_t;   // One register word
  typedef enum {QEU_M_OFF, QEU_M_TIMER, QEU_M_IDX, QEU_M_MAX} qeu_mode_t;

  // Mode field to operating mode
  function automatic qeu_mode_t qeu_mode_decode(input logic [2:0] m);
    case (m)
      3'h1:          return QEU_M_TIMER;
      3'h4, 3'h6:    return QEU_M_IDX;
      3'h5, 3'h7:    return QEU_M_MAX;
      default:       return QEU_M_OFF;
    endcase
  endfunction
endpackage : qeu_pkg

/* File: src/qeu_top.sv */
// Purpose: Quadrature encoder unit with idle/sleep halt, interrupts and registers
// Assumes: One 50 MHz clock, synchronous active-low reset, pins asynchronous
// Notes:   Register read data valid the cycle after the read strobe
`timescale 1ns/1ps
`include "qeu_regs.svh"
module qeu_top (
  // Clock and reset
  input  wire logic              clk_sys_i,
  input  wire logic              resetn_i,
  // Register port
  input  wire logic [11:0]       addr_i,
  input  wire logic [31:0]       wdata_i,
  input  wire logic              wr_i,
  input  wire logic              rd_i,
  output logic [31:0]            rdata_o,
  // Encoder pins
  input  wire logic              phase_a_i,
  input  wire logic              phase_b_i,
  input  wire logic              index_pin_i,
  // Processor power state
  input  wire logic              cpu_idle_i,
  input  wire logic              cpu_sleep_i,
  // Outputs
  output logic                   irq_o,
  output logic                   count_direction_o
);
  import qeu_pkg::*;

  // ==========================================================
  // Register decode
  function automatic logic reg_hit(input logic [11:0] a, input logic [9:0] idx);
    return (a[11:2] == idx) && (a[1:0] == 2'h0);
  endfunction

  // Timer prescale terminal count: 0, 7, 63, 255 (divide by 1, 8, 64, 256)
  function automatic logic [7:0] pre_limit(input logic [1:0] p);
    case (p)
      2'h0:    return 8'h00;
      2'h1:    return 8'h07;
      2'h2:    return 8'h3F;
      default: return 8'hFF;
    endcase
  endfunction

  qeu_word_t        ctrl_ff;       // Control register
  qeu_word_t        filt_ff;       // Filter control register
  qeu_word_t        pos_ff;        // Position / timer count
  qeu_word_t        max_ff;        // Maximum count / period
  qeu_word_t        pinsel_ff;     // Pin analog/digital select
  logic [3:0]       irqst_ff;      // Sticky event bits
  logic [3:0]       irqen_ff;      // Per-event enables
  logic [2:0]       sync1_ff;      // First sync stage a,b,index
  logic [2:0]       sync2_ff;      // Second sync stage
  logic [2:0]       hist_ff [3];   // Filter sample history
  logic [2:0]       filt_out_ff;   // Filtered levels
  logic [6:0]       fdiv_ff;       // Filter sample divider
  logic [1:0]       ab_prev_ff;    // Previous phase levels
  logic             idx_prev_ff;   // Previous qualified index
  logic             a_prev_ff;     // Previous phase A for timer
  logic             dir_ff;        // Decoded direction
  logic [7:0]       pre_ff;        // Timer prescaler
  qeu_mode_t        mode;
  logic             run;
  logic [2:0]       pins;
  logic             pa, pb, idx_q;
  logic             x4, enc_pulse, enc_up, idx_ev;
  logic             t_src, t_tick, t_up, gate_ev;
  logic             wr_pos, wr_ctrl, rd_st;
  logic             ev_roll, ev_per, ev_err;
  logic             fsample;

  // ==========================================================
  // Run control: sleep halts everything, idle halts only on request
  assign mode = qeu_mode_decode(ctrl_ff[`QEU_C_MODE]);
  assign run  = !cpu_sleep_i && !(cpu_idle_i && ctrl_ff[`QEU_C_SIDL]);

  // ==========================================================
  // Pin synchroniser, two flops before any use
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      sync1_ff <= 3'h0;
      sync2_ff <= 3'h0;
    end else begin
      sync1_ff <= {index_pin_i, phase_b_i, phase_a_i};
      sync2_ff <= sync1_ff;
    end
  end

  // ==========================================================
  // Noise filter: output moves only after three equal samples
  assign fsample = (fdiv_ff == ((7'h01 << filt_ff[`QEU_F_DIV]) - 7'h01));
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      fdiv_ff     <= 7'h00;
      filt_out_ff <= 3'h0;
      for (int i = 0; i < `QEU_FILT_LEN; i++) begin
        hist_ff[i] <= 3'h0;
      end
    end else if (run) begin
      fdiv_ff <= fsample ? 7'h00 : fdiv_ff + 7'h01;
      if (fsample) begin
        hist_ff[0] <= sync2_ff;
        hist_ff[1] <= hist_ff[0];
        hist_ff[2] <= hist_ff[1];
        for (int c = 0; c < 3; c++) begin
          if (hist_ff[0][c] == hist_ff[1][c] && hist_ff[1][c] == hist_ff[2][c]) begin
            filt_out_ff[c] <= hist_ff[0][c];
          end
        end
      end
    end
  end
  // Bypass when filter disabled; costs noise immunity, saves latency
  assign pins = filt_ff[`QEU_F_OUTEN] ? filt_out_ff : sync2_ff;
  assign pa   = ctrl_ff[`QEU_C_SWAP] ? pins[1] : pins[0];
  assign pb   = ctrl_ff[`QEU_C_SWAP] ? pins[0] : pins[1];

  // ==========================================================
  // Quadrature decode and index qualification
  assign x4        = ctrl_ff[9];
  assign enc_pulse = (mode == QEU_M_IDX || mode == QEU_M_MAX) &&
                     ((pa != ab_prev_ff[0]) || (x4 && (pb != ab_prev_ff[1])));
  assign enc_up    = pa ^ ab_prev_ff[1];
  assign idx_q     = pins[2] && (x4 ? (pb == filt_ff[10] && pa == filt_ff[9])
                                    : ((filt_ff[10] ? pb : pa) == filt_ff[9]));
  assign idx_ev    = (mode == QEU_M_IDX) && idx_q && !idx_prev_ff;

  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      ab_prev_ff  <= 2'h0;
      idx_prev_ff <= 1'b0;
      a_prev_ff   <= 1'b0;
      dir_ff      <= 1'b0;
    end else if (run) begin
      ab_prev_ff  <= {pb, pa};
      idx_prev_ff <= idx_q;
      a_prev_ff   <= pa;
      if (enc_pulse) begin
        dir_ff <= enc_up;
      end
    end
  end

  // ==========================================================
  // Timer clock: internal cycles or phase A rises, gated, prescaled
  assign t_src   = ctrl_ff[`QEU_C_TCS] ? (pa && !a_prev_ff)
                 : (!ctrl_ff[`QEU_C_GATE] || pa);
  assign gate_ev = (mode == QEU_M_TIMER) && run && ctrl_ff[`QEU_C_GATE] &&
                   !ctrl_ff[`QEU_C_TCS] && !pa && a_prev_ff;
  assign t_tick  = (mode == QEU_M_TIMER) && run && t_src &&
                   (pre_ff == pre_limit(ctrl_ff[`QEU_C_PRE]));
  assign t_up    = ctrl_ff[`QEU_C_DSRC] ? pb : ctrl_ff[`QEU_C_DIR];

  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i || wr_ctrl) begin
      pre_ff <= 8'h00;
    end else if ((mode == QEU_M_TIMER) && run && t_src) begin
      pre_ff <= t_tick ? 8'h00 : pre_ff + 8'h01;
    end
  end

  // ==========================================================
  // Position counter and its events
  assign wr_pos  = wr_i && reg_hit(addr_i, `QEU_IDX_POS);
  assign wr_ctrl = wr_i && reg_hit(addr_i, `QEU_IDX_CTRL);
  assign rd_st   = rd_i && reg_hit(addr_i, `QEU_IDX_IRQST);
  assign ev_per  = t_tick && (t_up ? (pos_ff == max_ff) : (pos_ff == 16'h0000));
  assign ev_roll = run && enc_pulse && (mode == QEU_M_MAX) &&
                   (enc_up ? (pos_ff == max_ff) : (pos_ff == 16'h0000));
  // Error when the next value would pass the expected wrap point
  assign ev_err  = run && enc_pulse && (mode == QEU_M_IDX) &&
                   (enc_up ? (pos_ff == max_ff) : (pos_ff == 16'h0000));

  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      pos_ff <= `QEU_RST_POS;
    end else if (wr_pos) begin
      pos_ff <= wdata_i[15:0]; // Software write beats counting
    end else if (run && idx_ev && ctrl_ff[`QEU_C_POSR]) begin
      pos_ff <= 16'h0000;
    end else if (ev_per || ev_roll) begin
      pos_ff <= (t_tick ? t_up : enc_up) ? 16'h0000 : max_ff;
    end else if (t_tick) begin
      pos_ff <= t_up ? pos_ff + 16'h0001 : pos_ff - 16'h0001;
    end else if (run && enc_pulse) begin
      pos_ff <= enc_up ? pos_ff + 16'h0001 : pos_ff - 16'h0001;
    end
  end

  // ==========================================================
  // Control, filter, maximum and pin-select registers
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      ctrl_ff <= `QEU_RST_CTRL;
    end else begin
      if (wr_ctrl) begin
        ctrl_ff <= wdata_i[15:0] & `QEU_MASK_CTRL;
      end
      // Hardware set of the error flag wins over a software clear
      if (ev_err) begin
        ctrl_ff[`QEU_C_ERR] <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      filt_ff   <= `QEU_RST_FILT;
      max_ff    <= `QEU_RST_MAX;
      pinsel_ff <= `QEU_RST_PINSEL;
      irqen_ff  <= 4'h0;
    end else if (wr_i) begin
      if (reg_hit(addr_i, `QEU_IDX_FILT)) begin
        filt_ff <= wdata_i[15:0] & `QEU_MASK_FILT;
      end
      if (reg_hit(addr_i, `QEU_IDX_MAX)) begin
        max_ff <= wdata_i[15:0];
      end
      if (reg_hit(addr_i, `QEU_IDX_PINSEL)) begin
        pinsel_ff <= wdata_i[15:0] & `QEU_MASK_PINSEL;
      end
      if (reg_hit(addr_i, `QEU_IDX_IRQEN)) begin
        irqen_ff <= wdata_i[3:0];
      end
    end
  end

  // ==========================================================
  // Sticky status: cleared only by reading it, new events win
  // A lost event here would leave software waiting forever
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      irqst_ff <= 4'h0;
    end else begin
      irqst_ff <= (rd_st ? 4'h0 : irqst_ff) |
                  {gate_ev, ev_per,
                   (run && idx_ev) || (ev_err && !filt_ff[`QEU_F_COUNT_ERROR_IRQ_DISABLE]),
                   ev_roll};
    end
  end

  // Level interrupt, masked per event
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(irqst_ff & irqen_ff);
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      count_direction_o <= 1'b0;
    end else begin
      count_direction_o <= (mode == QEU_M_TIMER) ? t_up : dir_ff;
    end
  end

  // ==========================================================
  // Read data, one cycle after the strobe, zero otherwise
  // Zero when idle so a stale word is never mistaken for an answer
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i || !rd_i) begin
      rdata_o <= 32'h0000_0000;
    end else if (reg_hit(addr_i, `QEU_IDX_CTRL)) begin
      rdata_o <= {16'h0000, ctrl_ff[15:13], pins[2],
                  (mode == QEU_M_TIMER) ? ctrl_ff[11] : dir_ff, ctrl_ff[10:0]};
    end else if (reg_hit(addr_i, `QEU_IDX_FILT)) begin
      rdata_o <= {16'h0000, filt_ff};
    end else if (reg_hit(addr_i, `QEU_IDX_POS)) begin
      rdata_o <= {16'h0000, pos_ff};
    end else if (reg_hit(addr_i, `QEU_IDX_MAX)) begin
      rdata_o <= {16'h0000, max_ff};
    end else if (reg_hit(addr_i, `QEU_IDX_PINSEL)) begin
      rdata_o <= {16'h0000, pinsel_ff};
    end else if (reg_hit(addr_i, `QEU_IDX_IRQST)) begin
      rdata_o <= {28'h0000000, irqst_ff};
    end else if (reg_hit(addr_i, `QEU_IDX_IRQEN)) begin
      rdata_o <= {28'h0000000, irqen_ff};
    end else begin
      rdata_o <= 32'h0000_0000; // Unmapped address
    end
  end

  // ==========================================================
  // Checks
  chk_idle_halt: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    cpu_idle_i && ctrl_ff[`QEU_C_SIDL] && !wr_pos && !wr_ctrl |=> $stable(pos_ff))
    else $error("position moved while halted in idle");
  chk_sleep_halt: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    cpu_sleep_i && !wr_pos && !rd_st |=> $stable(pos_ff) && $stable(irqst_ff & 4'hD))
    else $error("unit active during sleep");
  chk_idle_timer_runs: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    cpu_idle_i && !cpu_sleep_i && !ctrl_ff[`QEU_C_SIDL] && t_tick && t_up &&
    pos_ff != max_ff && !wr_pos |=> pos_ff == $past(pos_ff) + 16'h0001)
    else $error("timer did not count in idle");
  chk_idle_runs: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    cpu_idle_i && !cpu_sleep_i && !ctrl_ff[`QEU_C_SIDL] |-> run)
    else $error("unit stopped in idle with stop bit clear");
  chk_period_match: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    t_tick && t_up && pos_ff == max_ff && !wr_pos && !rd_st |=>
    pos_ff == 16'h0000 && irqst_ff[`QEU_S_PER])
    else $error("period match not handled");
  chk_flag_sticky: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    irqst_ff[`QEU_S_INDEX] && !rd_st |=> irqst_ff[`QEU_S_INDEX])
    else $error("flag cleared without software");
  chk_err_flag: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    ev_err && !irqst_ff[`QEU_S_INDEX] |=> ctrl_ff[`QEU_C_ERR] &&
    (irqst_ff[`QEU_S_INDEX] == !$past(filt_ff[8]) || $past(idx_ev)))
    else $error("count error not flagged");
  chk_index_event: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    run && idx_ev |=> irqst_ff[`QEU_S_INDEX])
    else $error("index event lost");
  chk_irq_masked: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    (irqst_ff & irqen_ff) == 4'h0 |=> !irq_o)
    else $error("interrupt without enabled flag");
  chk_irq_level: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    $rose(irqst_ff[0]) && irqen_ff[0] && !rd_st |=> irq_o [*2])
    else $error("interrupt level not held");
  chk_reset_clear: assert property (@(posedge clk_sys_i)
    !resetn_i |=> ctrl_ff == 16'h0000 && filt_ff == 16'h0000 && max_ff == 16'hFFFF)
    else $error("reset values wrong");
  chk_unimpl_zero: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    rd_i && reg_hit(addr_i, `QEU_IDX_FILT) |=> (rdata_o & 32'hFFFF_F80F) == 32'h0)
    else $error("unimplemented bits read nonzero");

  // Event, mask and register checks
  chk_roll_event: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    ev_roll && !wr_pos |=> irqst_ff[`QEU_S_ROLL] &&
    (pos_ff == ($past(enc_up) ? 16'h0000 : $past(max_ff))))
    else $error("rollover not flagged");
  chk_err_masked: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    ev_err && filt_ff[`QEU_F_COUNT_ERROR_IRQ_DISABLE] && !irqst_ff[`QEU_S_INDEX] && !idx_ev |=>
    !irqst_ff[`QEU_S_INDEX])
    else $error("masked count error raised the flag");
  chk_irq_set: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    (irqst_ff & irqen_ff) != 4'h0 |=> irq_o)
    else $error("enabled flag without interrupt");
  chk_ctrl_mask: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    wr_ctrl && !ev_err |=> ctrl_ff == ($past(wdata_i[15:0]) & `QEU_MASK_CTRL))
    else $error("control write kept unimplemented bits");
  chk_read_idle: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    !rd_i |=> rdata_o == 32'h0000_0000)
    else $error("read data present without a read");

  // Cover points of the main scenarios
  cov_idle_halt:  cover property (@(posedge clk_sys_i) cpu_idle_i && !run);
  cov_period:     cover property (@(posedge clk_sys_i) ev_per);
  cov_index:      cover property (@(posedge clk_sys_i) idx_ev && run);
  cov_irq_rise:   cover property (@(posedge clk_sys_i) $rose(irq_o));
endmodule // qeu_top

/* File: tb/qeu_enc_model.sv */
// Purpose: Behavioural incremental encoder driving phase and index pins
// Assumes: Bench requests one quadrature step per pulse of step_i
// Notes:   Pins are push-pull, so they always hold a defined level
`timescale 1ns/1ps
module qeu_enc_model (
  // Clock
  input  wire logic clk_sys_i,
  // Bench commands
  input  wire logic step_i,
  input  wire logic fwd_i,
  input  wire logic index_req_i,
  // Encoder pins
  output logic      phase_a_o,
  output logic      phase_b_o,
  output logic      index_o
);
  // ==========================================================
  // Shaft position
  logic [1:0] pos_ff = 2'h0;  // Quarter-cycle position

  // One edge per step; forward gives phase A leading
  always_ff @(posedge clk_sys_i) begin
    if (step_i) begin
      pos_ff <= fwd_i ? pos_ff + 2'h1 : pos_ff - 2'h1;
    end
  end

  // Gray order 00,10,11,01 of (A,B)
  assign phase_a_o = pos_ff[0] ^ pos_ff[1];
  assign phase_b_o = pos_ff[1];
  assign index_o   = index_req_i;
endmodule // qeu_enc_model

/* File: tb/testbench.sv */
// Purpose: Self-checking bench for the encoder unit registers and power modes
// Assumes: Pins settle within a few cycles with the filter off
// Notes:   Timer deltas are measured between two reads a fixed gap apart
`timescale 1ns/1ps
`include "qeu_regs.svh"
module testbench;
  // ==========================================================
  // Addresses
  localparam logic [11:0] A_CTRL = {`QEU_IDX_CTRL, 2'b00};
  localparam logic [11:0] A_FILT = {`QEU_IDX_FILT, 2'b00};
  localparam logic [11:0] A_POS  = {`QEU_IDX_POS, 2'b00};
  localparam logic [11:0] A_MAX  = {`QEU_IDX_MAX, 2'b00};
  localparam logic [11:0] A_PIN  = {`QEU_IDX_PINSEL, 2'b00};
  localparam logic [11:0] A_IST  = {`QEU_IDX_IRQST, 2'b00};
  localparam logic [11:0] A_IEN  = {`QEU_IDX_IRQEN, 2'b00};
  // ==========================================================
  // Signals
  logic        clk_sys_i = 1'b0;
  logic        resetn_i;
  logic [11:0] addr_i;
  logic [31:0] wdata_i;
  logic        wr_i;
  logic        rd_i;
  logic [31:0] rdata_o;
  logic        phase_a;
  logic        phase_b;
  logic        index_pin;
  logic        cpu_idle_i;
  logic        cpu_sleep_i;
  logic        irq_o;
  logic        count_direction_o;
  logic        step;
  logic        idx_req;
  logic [31:0] d;
  int          bad_count = 0;
  int          cmp_count = 0;
  int          cyc_count = 0;

  always #10 clk_sys_i = ~clk_sys_i;

  qeu_top u_qeu_top (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .phase_a_i(phase_a), .phase_b_i(phase_b), .index_pin_i(index_pin),
    .cpu_idle_i(cpu_idle_i), .cpu_sleep_i(cpu_sleep_i), .irq_o(irq_o),
    .count_direction_o(count_direction_o));

  qeu_enc_model u_qeu_enc_model (.clk_sys_i(clk_sys_i), .step_i(step), .fwd_i(1'b1),
    .index_req_i(idx_req), .phase_a_o(phase_a), .phase_b_o(phase_b), .index_o(index_pin));

  // ==========================================================
  // Bus and check tasks
  task automatic wr_reg(input logic [11:0] a, input logic [15:0] v);
    @(posedge clk_sys_i);
    addr_i <= a;
    wdata_i <= {16'h0000, v};
    wr_i <= 1'b1;
    @(posedge clk_sys_i);
    wr_i <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [11:0] a, output logic [31:0] v);
    @(posedge clk_sys_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_sys_i);
    rd_i <= 1'b0;
    @(posedge clk_sys_i);
    v = rdata_o;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] v;
    rd_reg(a, v);
    chk(v, exp);
  endtask

  // One quadrature step forward
  task automatic pulse_step();
    @(posedge clk_sys_i);
    step <= 1'b1;
    @(posedge clk_sys_i);
    step <= 1'b0;
    repeat (8) @(posedge clk_sys_i);
  endtask

  // Timer mode run under a power state; two reads twelve edges apart
  task automatic run_case(input logic idle, input logic slp, input logic sidl,
                          input logic up, input logic [15:0] delta);
    logic [31:0] p0;
    logic [31:0] p1;
    wr_reg(A_CTRL, {2'b00, sidl, 1'b0, up, 11'h100});
    cpu_idle_i <= idle;
    cpu_sleep_i <= slp;
    repeat (3) @(posedge clk_sys_i);
    if (!slp) begin
      chk({31'h0, count_direction_o}, {31'h0, up});
    end
    rd_reg(A_POS, p0);
    repeat (9) @(posedge clk_sys_i);
    rd_reg(A_POS, p1);
    chk({16'h0000, p1[15:0] - p0[15:0]}, {16'h0000, delta});
  endtask

  task automatic final_report();
    $display("mismatches=%0d comparisons=%0d", bad_count, cmp_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Hang guard; the full run needs well under a thousand cycles
  always @(posedge clk_sys_i) begin
    cyc_count <= cyc_count + 1;
    if (cyc_count == 5000) begin
      bad_count++;
      final_report();
    end
  end

  // ==========================================================
  // Main sequence
  logic [11:0] addrs [4] = '{A_FILT, A_PIN, A_IEN, A_MAX};
  logic [15:0] masks [4] = '{16'h07F0, 16'h01FF, 16'h000F, 16'hFFFF};

  initial begin
    resetn_i = 1'b0;
    {addr_i, wdata_i, wr_i, rd_i} = '0;
    {cpu_idle_i, cpu_sleep_i, step, idx_req} = '0;
    repeat (3) @(posedge clk_sys_i);
    resetn_i <= 1'b1;
    // Reset values
    rchk(A_CTRL, 32'h0);
    rchk(A_FILT, 32'h0);
    rchk(A_POS, 32'h0);
    rchk(A_MAX, 32'hFFFF);
    rchk(A_PIN, 32'h0);
    // Unimplemented bits, unmapped and misaligned places
    for (int i = 0; i < 4; i++) begin
      wr_reg(addrs[i], 16'hFFFF);
      rchk(addrs[i], {16'h0000, masks[i]});
    end
    wr_reg(12'h500, 16'hFFFF);
    rchk(12'h500, 32'h0);
    rchk(A_FILT + 12'h1, 32'h0);
    wr_reg(A_FILT, 16'h0000);
    wr_reg(A_IEN, 16'h0000);
    // Timer under each power state
    run_case(1'b0, 1'b0, 1'b0, 1'b1, 16'h000C);
    run_case(1'b1, 1'b0, 1'b0, 1'b1, 16'h000C);
    run_case(1'b1, 1'b0, 1'b1, 1'b1, 16'h0000);
    run_case(1'b0, 1'b0, 1'b1, 1'b1, 16'h000C);
    run_case(1'b0, 1'b1, 1'b0, 1'b1, 16'h0000);
    run_case(1'b1, 1'b0, 1'b0, 1'b0, 16'hFFF4);
    // Period match interrupt, then frozen by sleep
    cpu_idle_i <= 1'b0;
    wr_reg(A_MAX, 16'h0020);
    wr_reg(A_CTRL, 16'h0900);
    wr_reg(A_POS, 16'h0000);
    wr_reg(A_IEN, 16'h0004);
    repeat (45) @(posedge clk_sys_i);
    cpu_sleep_i <= 1'b1;
    repeat (40) @(posedge clk_sys_i);
    chk({31'h0, irq_o}, 32'h1);
    wr_reg(A_IEN, 16'h0000);
    repeat (2) @(posedge clk_sys_i);
    chk({31'h0, irq_o}, 32'h0);
    wr_reg(A_IEN, 16'h0004);
    repeat (2) @(posedge clk_sys_i);
    chk({31'h0, irq_o}, 32'h1);
    rchk(A_IST, 32'h4);
    rchk(A_IST, 32'h0);
    chk({31'h0, irq_o}, 32'h0);
    cpu_sleep_i <= 1'b0;
    // Count error in x4 index mode, then with its interrupt disabled
    wr_reg(A_IEN, 16'h0002);
    wr_reg(A_MAX, 16'h0010);
    wr_reg(A_CTRL, 16'h0600);
    rd_reg(A_IST, d);
    wr_reg(A_POS, 16'h0010);
    pulse_step();
    rchk(A_IST, 32'h2);
    rd_reg(A_CTRL, d);
    chk(d & 32'h8000, 32'h8000);
    wr_reg(A_FILT, 16'h0700);
    wr_reg(A_POS, 16'h0010);
    pulse_step();
    rchk(A_IST, 32'h0);
    // Qualified index with both phases high
    idx_req <= 1'b1;
    repeat (6) @(posedge clk_sys_i);
    idx_req <= 1'b0;
    repeat (6) @(posedge clk_sys_i);
    rchk(A_IST, 32'h2);
    // Rollover at maximum in x4 count-to-maximum mode
    wr_reg(A_IEN, 16'h0001);
    wr_reg(A_CTRL, 16'h0700);
    wr_reg(A_POS, 16'h0010);
    pulse_step();
    chk({31'h0, irq_o}, 32'h1);
    rchk(A_POS, 32'h0);
    rchk(A_IST, 32'h1);
    // Second reset clears stop-in-idle
    wr_reg(A_CTRL, 16'h2000);
    rd_reg(A_CTRL, d);
    chk(d & 32'h2000, 32'h2000);
    resetn_i <= 1'b0;
    repeat (3) @(posedge clk_sys_i);
    resetn_i <= 1'b1;
    rd_reg(A_CTRL, d);
    chk(d & 32'hF7FF, 32'h0);
    final_report();
  end
endmodule // testbench
